// ===== xotc_pkg.sv
// Contract
// - trim code maps linearly, 0x00 least capacitance, 0xFF most, 256 steps.
// - five low trim bits drive five binary weighted capacitor enables directly.
// - three high trim bits thermometer decode into seven 32-unit enables.
// - crystal ready interrupt fires when start-up counter reaches ready count limit.
// - start-up counter ticks on fast RC at power-up, low-power clock on wake.
// - hardware enables fast crystal and applies stored trim with no software.
// - counter mode applies trim at target minus one; current mode on current drop.
// - current mode copies start-up counter into snapshot when trim applied flag rises.
// - settle done flag rises when settle counter reaches the settle threshold.
// - dual-rate RC runs fast rate during power-up to shorten the sequence.
// - software loads count N and source code; device measures against reference.
// - go bit starts measurement, device clears it and shows 32-bit result.
package xotc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CAP_TRIM = 8'h00; // xtal_cap_trim
  localparam logic [7:0] A_STORED_TRIM = 8'h04; // stored_trim_value
  localparam logic [7:0] A_READY_LIMIT = 8'h08; // ready_count_limit
  localparam logic [7:0] A_TRIM_CTRL = 8'h0c; // apply select, settle threshold
  localparam logic [7:0] A_STARTUP_TARGET = 8'h10; // startup_count_target
  localparam logic [7:0] A_SNAPSHOT = 8'h14; // startup_count_snapshot
  localparam logic [7:0] A_SYS_STAT = 8'h18; // sequence status
  localparam logic [7:0] A_CAL_CTRL = 8'h1c; // source code and go bit
  localparam logic [7:0] A_REF_COUNT = 8'h20; // ref_period_count
  localparam logic [7:0] A_RESULT_HIGH = 8'h24; // calib_result_high
  localparam logic [7:0] A_RESULT_LOW = 8'h28; // calib_result_low
  localparam logic [7:0] A_HANDOFF = 8'h2c; // osc_handoff_register
  localparam logic [7:0] A_IRQ_STAT = 8'h30; // sticky events, write one clears
  localparam logic [7:0] A_IRQ_MASK = 8'h34; // interrupt mask

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TC_SELECT_BIT = 0; // 0 counter mode, 1 current mode
  localparam int TC_SETTLE_LSB = 8;
  localparam int SETTLE_W = 8;
  localparam int CAL_SRC_LSB = 0;
  localparam int CAL_SRC_W = 2;
  localparam int CAL_GO_BIT = 2;
  localparam int ST_SETTLE_BIT = 0;
  localparam int ST_APPLIED_BIT = 1;
  localparam int ST_READY_BIT = 2;
  localparam int ST_XTAL_EN_BIT = 3;
  localparam int ST_DRC_FAST_BIT = 4;
  localparam int IRQ_READY = 0; // crystal_ready_interrupt
  localparam int IRQ_TRIM = 1; // trim applied
  localparam int IRQ_CAL = 2; // calibration done
  localparam int IRQ_W = 3;
  localparam int TRIM_W = 8;
  localparam int BIN_W = 5;
  localparam int THERM_W = 7;
  localparam int REF_N_W = 16;
  localparam int RES_W = 32;
  localparam int HALF_W = 16;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h80;
  localparam logic [15:0] READY_LIMIT_RST = 16'h0040;
  localparam logic [15:0] TARGET_RST = 16'h0020;
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 8'h08;
  localparam logic [REF_N_W-1:0] REF_N_RST = 16'h0100;
  localparam logic TRIM_SEL_COUNTER = 1'b0;
  localparam logic TRIM_SEL_CURRENT = 1'b1;
  localparam int NUM_SRC = 4; // 0 dual-rate RC, 1 fast RC, 2 slow xtal, 3 precise RC

  // start-up sequence states
  typedef enum logic [2:0] {
    XOTC_IDLE = 3'b001,
    XOTC_STARTUP = 3'b010,
    XOTC_SETTLE = 3'b100
  } xotc_state_t;

  // capacitor bank enables
  typedef struct packed {
    logic [THERM_W-1:0] therm; // 32-unit capacitors
    logic [BIN_W-1:0] bin; // binary weighted capacitors
  } xotc_cap_t;

endpackage

// ===== xotc_top.sv
// Our own choices: the Avalon-MM register port and the register offsets.
module xotc_top #(
  parameter int CNT_W = 16 // start-up counter width
) (
  input wire logic I_SYS_CLK, // system clock
  input wire logic I_RST_N, // async reset, active low
  input wire logic [7:0] I_AVS_ADDRESS, // byte address
  input wire logic I_AVS_READ, // read request
  input wire logic I_AVS_WRITE, // write request
  input wire logic [31:0] I_AVS_WRITEDATA, // write data
  input wire logic [3:0] I_AVS_BYTEENABLE, // byte lanes
  output logic [31:0] O_AVS_READDATA, // read data
  output logic O_AVS_WAITREQUEST, // stall
  input wire logic I_XTAL_START, // pulse: start crystal sequence
  input wire logic I_WAKE_UP, // level: 1 wake-up, 0 power-up
  input wire logic I_XTAL_STOP, // pulse: crystal switched off
  input wire logic I_FAST_RC_TICK, // fast RC period pulse
  input wire logic I_LP_TICK, // low-power clock period pulse
  input wire logic I_XTAL_TICK, // crystal period pulse
  input wire logic I_CUR_DROP, // oscillator current dropped
  input wire logic [xotc_pkg::NUM_SRC-1:0] I_SRC_TICK, // calib sources
  input wire logic I_REF_TICK, // 16 MHz reference pulse
  output logic O_XTAL_EN, // crystal enable
  output xotc_pkg::xotc_cap_t O_CAP, // capacitor enables
  output logic O_DRC_FAST, // dual-rate RC at fast rate
  output logic O_IRQ // level interrupt
);
  import xotc_pkg::*;
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  xotc_state_t state_q;
  logic ack_q, req, wr, start, stop, sel_tick, apply, ready_hit;
  logic [7:0] waddr;
  logic [31:0] rd_d;
  logic [TRIM_W-1:0] cap_trim_q, stored_trim_q, handoff_q;
  logic [CNT_W-1:0] ready_limit_q, target_q, snapshot_q, ic_cnt_q;
  logic trim_sel_q, wake_q, applied_q, rdy_seen_q, settle_done_q, drc_q;
  logic [SETTLE_W-1:0] settle_n_q, settle_cnt_q;
  logic [CAL_SRC_W-1:0] cal_src_q;
  logic cal_go_q, cal_start, cal_done, src_tick;
  logic [REF_N_W-1:0] ref_n_q, src_cnt_q;
  logic [RES_W-1:0] ref_cnt_q, result_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // thermometer decode: output i high when code exceeds i
  function automatic logic [THERM_W-1:0] therm(input logic [2:0] code);
    logic [THERM_W-1:0] t;
    t = '0;
    for (int i = 0; i < THERM_W; i++) begin
      t[i] = (32'(code) > i);
    end
    return t;
  endfunction

  // ---------------------------------------------------------------
  // bus slave: one wait cycle, then answer
  // ---------------------------------------------------------------
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign O_AVS_WAITREQUEST = req & ~ack_q;
  assign wr = I_AVS_WRITE & ack_q;
  assign waddr = {I_AVS_ADDRESS[7:2], 2'b00};
  // acknowledge toggles so each request waits exactly once
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
  // read mux, unmapped reads return zero
  always_comb begin
    rd_d = '0;
    unique case (waddr)
      A_CAP_TRIM: rd_d = 32'(cap_trim_q);
      A_STORED_TRIM: rd_d = 32'(stored_trim_q);
      A_READY_LIMIT: rd_d = 32'(ready_limit_q);
      A_TRIM_CTRL: begin
        rd_d[TC_SELECT_BIT] = trim_sel_q;
        rd_d[TC_SETTLE_LSB +: SETTLE_W] = settle_n_q;
      end
      A_STARTUP_TARGET: rd_d = 32'(target_q);
      A_SNAPSHOT: rd_d = 32'(snapshot_q);
      A_SYS_STAT: begin
        rd_d[ST_SETTLE_BIT] = settle_done_q;
        rd_d[ST_APPLIED_BIT] = applied_q;
        rd_d[ST_READY_BIT] = rdy_seen_q;
        rd_d[ST_XTAL_EN_BIT] = O_XTAL_EN;
        rd_d[ST_DRC_FAST_BIT] = drc_q;
      end
      A_CAL_CTRL: begin
        rd_d[CAL_SRC_LSB +: CAL_SRC_W] = cal_src_q;
        rd_d[CAL_GO_BIT] = cal_go_q;
      end
      A_REF_COUNT: rd_d = 32'(ref_n_q);
      A_RESULT_HIGH: rd_d = 32'(result_q[RES_W-1 -: HALF_W]);
      A_RESULT_LOW: rd_d = 32'(result_q[HALF_W-1:0]);
      A_HANDOFF: rd_d = 32'(handoff_q);
      A_IRQ_STAT: rd_d = 32'(irq_stat_q);
      A_IRQ_MASK: rd_d = 32'(irq_mask_q);
      default: rd_d = '0;
    endcase
  end
  // read data latched in the wait cycle, valid when waitrequest drops
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AVS_READDATA <= '0;
    end else if (I_AVS_READ && !ack_q) begin
      O_AVS_READDATA <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // software configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      stored_trim_q <= TRIM_RST;
      ready_limit_q <= CNT_W'(READY_LIMIT_RST);
      target_q <= CNT_W'(TARGET_RST);
      trim_sel_q <= TRIM_SEL_COUNTER;
      settle_n_q <= SETTLE_RST;
      ref_n_q <= REF_N_RST;
      handoff_q <= '0;
      irq_mask_q <= '0;
    end else if (wr) begin
      unique case (waddr)
        A_STORED_TRIM: stored_trim_q <= TRIM_W'(merge(32'(stored_trim_q),
            I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        A_READY_LIMIT: ready_limit_q <= CNT_W'(merge(32'(ready_limit_q),
            I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        A_STARTUP_TARGET: target_q <= CNT_W'(merge(32'(target_q),
            I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        A_TRIM_CTRL: begin
          if (I_AVS_BYTEENABLE[0]) begin
            trim_sel_q <= I_AVS_WRITEDATA[TC_SELECT_BIT];
          end
          if (I_AVS_BYTEENABLE[1]) begin
            settle_n_q <= I_AVS_WRITEDATA[TC_SETTLE_LSB +: SETTLE_W];
          end
        end
        A_REF_COUNT: if (!cal_go_q) begin
          ref_n_q <= REF_N_W'(merge(32'(ref_n_q), I_AVS_WRITEDATA,
              I_AVS_BYTEENABLE));
        end
        A_HANDOFF: handoff_q <= TRIM_W'(merge(32'(handoff_q),
            I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        A_IRQ_MASK: irq_mask_q <= IRQ_W'(merge(32'(irq_mask_q),
            I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        default: ;
      endcase
    end
  end
  // live trim code: software write, overridden by automatic apply
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cap_trim_q <= TRIM_RST;
    end else if (apply) begin
      cap_trim_q <= stored_trim_q;
    end else if (wr && waddr == A_CAP_TRIM) begin
      cap_trim_q <= TRIM_W'(merge(32'(cap_trim_q), I_AVS_WRITEDATA,
          I_AVS_BYTEENABLE));
    end
  end
  // capacitor bank enables, linear over 256 codes
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CAP <= '0;
    end else begin
      O_CAP.bin <= cap_trim_q[BIN_W-1:0];
      O_CAP.therm <= therm(cap_trim_q[TRIM_W-1:BIN_W]);
    end
  end

  // ---------------------------------------------------------------
  // crystal start-up sequence
  // ---------------------------------------------------------------
  assign start = I_XTAL_START;
  assign stop = I_XTAL_STOP & ~start;
  assign sel_tick = wake_q ? I_LP_TICK : I_FAST_RC_TICK;
  assign apply = (state_q == XOTC_STARTUP) && !start && !stop &&
      ((trim_sel_q == TRIM_SEL_COUNTER) ?
      (ic_cnt_q == CNT_W'(target_q - 1'b1)) : I_CUR_DROP);
  assign ready_hit = (state_q != XOTC_IDLE) && !start && !rdy_seen_q &&
      (ic_cnt_q == ready_limit_q);
  assign O_XTAL_EN = (state_q != XOTC_IDLE);
  assign O_DRC_FAST = drc_q;
  // sequence state; a start always restarts from the beginning
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= XOTC_IDLE;
    end else if (start) begin
      state_q <= XOTC_STARTUP;
    end else if (stop) begin
      state_q <= XOTC_IDLE;
    end else begin
      unique case (state_q)
        XOTC_IDLE: state_q <= XOTC_IDLE;
        XOTC_STARTUP: if (apply) state_q <= XOTC_SETTLE;
        XOTC_SETTLE: state_q <= XOTC_SETTLE;
        default: state_q <= XOTC_IDLE;
      endcase
    end
  end
  // wake or power-up caught at start
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake_q <= 1'b0;
    end else if (start) begin
      wake_q <= I_WAKE_UP;
    end
  end
  // start-up counter, saturating
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ic_cnt_q <= '0;
    end else if (start) begin
      ic_cnt_q <= '0;
    end else if (O_XTAL_EN && sel_tick && !(&ic_cnt_q)) begin
      ic_cnt_q <= ic_cnt_q + 1'b1;
    end
  end
  // trim applied flag, ready seen flag and snapshot
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      applied_q <= 1'b0;
      rdy_seen_q <= 1'b0;
      snapshot_q <= '0;
    end else begin
      if (start || stop) begin
        applied_q <= 1'b0;
        rdy_seen_q <= 1'b0;
      end else begin
        if (apply) applied_q <= 1'b1;
        if (ready_hit) rdy_seen_q <= 1'b1;
      end
      if (apply && trim_sel_q == TRIM_SEL_CURRENT) begin
        snapshot_q <= ic_cnt_q;
      end
    end
  end
  // settle counter and settle done flag
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      settle_cnt_q <= '0;
      settle_done_q <= 1'b0;
    end else if (start || stop) begin
      settle_cnt_q <= '0;
      settle_done_q <= 1'b0;
    end else if (state_q == XOTC_SETTLE) begin
      if (I_XTAL_TICK && !(&settle_cnt_q)) begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
      end
      if (settle_cnt_q >= settle_n_q) begin
        settle_done_q <= 1'b1;
      end
    end
  end
  // dual-rate RC fast during a power-up sequence until crystal ready
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      drc_q <= 1'b0;
    end else if (start) begin
      drc_q <= ~I_WAKE_UP;
    end else if (stop || ready_hit) begin
      drc_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // reference counter calibration
  // ---------------------------------------------------------------
  assign cal_start = wr && waddr == A_CAL_CTRL && I_AVS_BYTEENABLE[0] &&
      I_AVS_WRITEDATA[CAL_GO_BIT] && !cal_go_q;
  assign src_tick = I_SRC_TICK[cal_src_q];
  assign cal_done = cal_go_q && src_tick &&
      ({1'b0, src_cnt_q} + 1'b1 >= {1'b0, ref_n_q});
  // go bit, source select and counts
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cal_go_q <= 1'b0;
      cal_src_q <= '0;
      src_cnt_q <= '0;
      ref_cnt_q <= '0;
    end else if (cal_start) begin
      cal_go_q <= 1'b1;
      cal_src_q <= I_AVS_WRITEDATA[CAL_SRC_LSB +: CAL_SRC_W];
      src_cnt_q <= '0;
      ref_cnt_q <= '0;
    end else if (cal_go_q) begin
      if (cal_done) cal_go_q <= 1'b0;
      if (src_tick) src_cnt_q <= src_cnt_q + 1'b1;
      if (I_REF_TICK) ref_cnt_q <= ref_cnt_q + 1'b1;
    end else if (wr && waddr == A_CAL_CTRL && I_AVS_BYTEENABLE[0]) begin
      cal_src_q <= I_AVS_WRITEDATA[CAL_SRC_LSB +: CAL_SRC_W];
    end
  end
  // result counts reference edges over N source periods
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result_q <= '0;
    end else if (cal_done) begin
      result_q <= ref_cnt_q + RES_W'(I_REF_TICK);
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky status, set wins over write-one clear
  // ---------------------------------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_READY] = ready_hit;
    irq_ev[IRQ_TRIM] = apply;
    irq_ev[IRQ_CAL] = cal_done;
  end
  // sticky status, events or-ed in every cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_stat_q <= '0;
    end else if (wr && waddr == A_IRQ_STAT && I_AVS_BYTEENABLE[0]) begin
      irq_stat_q <= (irq_stat_q & ~I_AVS_WRITEDATA[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end
  assign O_IRQ = |(irq_stat_q & irq_mask_q);
endmodule // xotc_top

// ===== xotc_monitor.sv
module xotc_monitor (
  input wire logic I_SYS_CLK, // system clock
  input wire logic I_RST_N, // async reset, active low
  input wire logic I_AVS_READ, // read request
  input wire logic I_AVS_WRITE, // write request
  input wire logic O_AVS_WAITREQUEST, // stall
  input wire logic I_XTAL_START, // sequence start pulse
  input wire logic I_WAKE_UP, // wake-up when high
  input wire logic I_XTAL_STOP, // crystal off pulse
  input wire logic O_XTAL_EN, // crystal enable
  input wire xotc_pkg::xotc_cap_t O_CAP, // capacitor enables
  input wire logic O_DRC_FAST // dual-rate RC fast rate
);
  timeunit 1ns;
  timeprecision 1ns;
  import xotc_pkg::*;
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  property p_en_start;
    I_XTAL_START |=> O_XTAL_EN;
  endproperty
  a_en_start: assert property (p_en_start)
    else $error("crystal not enabled after start");
  property p_en_rise;
    $rose(O_XTAL_EN) |-> $past(I_XTAL_START);
  endproperty
  a_en_rise: assert property (p_en_rise)
    else $error("crystal enabled without a start");
  property p_stop;
    I_XTAL_STOP && !I_XTAL_START |=> !O_XTAL_EN;
  endproperty
  a_stop: assert property (p_stop)
    else $error("crystal still enabled after stop");
  property p_drc_pwr;
    I_XTAL_START && !I_WAKE_UP |=> O_DRC_FAST;
  endproperty
  a_drc_pwr: assert property (p_drc_pwr)
    else $error("rc not at fast rate on power-up");
  property p_drc_wake;
    I_XTAL_START && I_WAKE_UP |=> !O_DRC_FAST;
  endproperty
  a_drc_wake: assert property (p_drc_wake)
    else $error("rc at fast rate on wake-up");
  property p_drc_rise;
    $rose(O_DRC_FAST) |-> $past(I_XTAL_START) && !$past(I_WAKE_UP);
  endproperty
  a_drc_rise: assert property (p_drc_rise)
    else $error("fast rate without power-up start");
  property p_therm;
    ((O_CAP.therm + 7'h01) & O_CAP.therm) == 7'h00;
  endproperty
  a_therm: assert property (p_therm)
    else $error("upper bank not thermometer coded");
  property p_cap_chg;
    $changed(O_CAP) |-> $past(I_AVS_WRITE, 2) || $past(O_XTAL_EN, 2)
      || !$past(I_RST_N, 2);
  endproperty
  a_cap_chg: assert property (p_cap_chg)
    else $error("capacitor enables moved without cause");
  property p_wait_first;
    (I_AVS_READ || I_AVS_WRITE) && !$past(I_AVS_READ)
      && !$past(I_AVS_WRITE) |-> O_AVS_WAITREQUEST;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("new request not stalled one cycle");
  property p_wait_once;
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("stall longer than one cycle");
endmodule // xotc_monitor

bind xotc_top xotc_monitor u_mon (.I_SYS_CLK, .I_RST_N, .I_AVS_READ,
  .I_AVS_WRITE, .O_AVS_WAITREQUEST, .I_XTAL_START, .I_WAKE_UP,
  .I_XTAL_STOP, .O_XTAL_EN, .O_CAP, .O_DRC_FAST);

// ===== xotc_osc_model.sv
module xotc_osc_model (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_xtal_en, // crystal enable from the block
  input wire logic i_drop_cmd, // bench asks for a current drop
  output logic o_fast_rc_tick, // fast RC, every 2 cycles
  output logic o_lp_tick, // low-power clock, every 8 cycles
  output logic o_xtal_tick, // crystal period while enabled
  output logic o_cur_drop, // crystal current has dropped
  output logic [3:0] o_src_tick, // source s every 3+3*s*s cycles
  output logic o_ref_tick // reference, one pulse every clock cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // oscillator cells
  // ------------------------------------------------------------
  int unsigned phase_q;
  // free-running phase shared by all divided ticks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= 0;
    end else begin
      phase_q <= phase_q + 1;
    end
  end
  // a crystal that is off gives no periods and draws no current
  always_comb begin
    o_fast_rc_tick = phase_q[0];
    o_lp_tick = (phase_q % 8) == 7;
    o_xtal_tick = i_xtal_en && phase_q[0];
    o_cur_drop = i_xtal_en && i_drop_cmd;
    o_ref_tick = 1'b1;
    for (int s = 0; s < 4; s++) begin
      o_src_tick[s] = (phase_q % (3 + 3 * s * s)) == 0;
    end
  end
endmodule // xotc_osc_model

// ===== test_xtal_trim_and_osc_calibration.sv
`define CHK(nm, e, g) \
  begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_xtal_trim_and_osc_calibration;
  timeunit 1ns;
  timeprecision 1ns;
  import xotc_pkg::*;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic start = 1'b0, wake = 1'b0, stop = 1'b0, drop = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic fast_t, lp_t, xtal_t, cur_t, ref_t, wreq, xtal_en, drc, irq;
  logic [3:0] src_t;
  xotc_cap_t cap;
  int n_fail = 0, samples_checked = 0, cycles = 0;

  // 10 MHz clock keeps the bus at 8 MHz or more
  always #50 clk = ~clk;

  xotc_top DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq), .I_XTAL_START(start), .I_WAKE_UP(wake),
    .I_XTAL_STOP(stop), .I_FAST_RC_TICK(fast_t), .I_LP_TICK(lp_t),
    .I_XTAL_TICK(xtal_t), .I_CUR_DROP(cur_t), .I_SRC_TICK(src_t),
    .I_REF_TICK(ref_t), .O_XTAL_EN(xtal_en), .O_CAP(cap),
    .O_DRC_FAST(drc), .O_IRQ(irq));
  xotc_osc_model u_osc (.i_clk(clk), .i_rst_n(rst_n), .i_xtal_en(xtal_en),
    .i_drop_cmd(drop), .o_fast_rc_tick(fast_t), .o_lp_tick(lp_t),
    .o_xtal_tick(xtal_t), .o_cur_drop(cur_t), .o_src_tick(src_t),
    .o_ref_tick(ref_t));

  // expected bank enables for a trim code
  function automatic xotc_cap_t exp_cap(input logic [7:0] c);
    exp_cap.bin = c[4:0];
    exp_cap.therm = 7'((8'h01 << c[7:5]) - 8'h01);
  endfunction

  // one transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdv(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rdv(a, q);
    `CHK("register read", e, q)
  endtask
  // one-cycle start pulse, power-up or wake-up
  task automatic kick(input logic w);
    @(posedge clk);
    start <= 1'b1; wake <= w;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask

  // reset values, unmapped space and handoff storage
  task automatic t_regs();
    rdc(A_CAP_TRIM, 32'(TRIM_RST));
    `CHK("cap after reset", exp_cap(TRIM_RST), cap)
    rdc(A_STORED_TRIM, 32'(TRIM_RST));
    rdc(A_READY_LIMIT, 32'(READY_LIMIT_RST));
    rdc(A_TRIM_CTRL, 32'(SETTLE_RST) << TC_SETTLE_LSB);
    rdc(A_STARTUP_TARGET, 32'(TARGET_RST));
    rdc(A_REF_COUNT, 32'(REF_N_RST));
    rdc(A_IRQ_MASK, 32'h0);
    rdc(8'h3c, 32'h0);
    wrt(A_HANDOFF, 32'h20);
    rdc(A_HANDOFF, 32'h20);
    wrt(A_HANDOFF, 32'h40);
    rdc(A_HANDOFF, 32'h40);
  endtask
  // trim code to both banks, ends and middle codes
  task automatic t_trim();
    logic [7:0] codes [5] = '{8'h00, 8'hff, 8'h25, 8'h5f, 8'ha3};
    foreach (codes[i]) begin
      wrt(A_CAP_TRIM, 32'(codes[i]));
      repeat (2) @(negedge clk);
      `CHK("cap bank", exp_cap(codes[i]), cap)
      rdc(A_CAP_TRIM, 32'(codes[i]));
    end
  endtask
  // power-up in counter mode, trim event masked
  task automatic t_pwr();
    int n;
    wrt(A_STORED_TRIM, 32'h3c);
    wrt(A_STARTUP_TARGET, 32'h6);
    wrt(A_READY_LIMIT, 32'ha);
    wrt(A_TRIM_CTRL, 32'h0200);
    wrt(A_IRQ_MASK, 32'h1);
    kick(1'b0);
    @(negedge clk);
    `CHK("xtal enable", 1'b1, xtal_en)
    `CHK("rc fast rate", 1'b1, drc)
    wait_irq(n);
    `CHK("ready time", 1'b1, n >= 16 && n <= 28)
    `CHK("rc slow after ready", 1'b0, drc)
    `CHK("trim applied", exp_cap(8'h3c), cap)
    rdc(A_IRQ_STAT, 32'h3);
    rdc(A_SYS_STAT, 32'h0f);
    wrt(A_IRQ_STAT, 32'h1);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rdc(A_IRQ_STAT, 32'h2);
  endtask
  // wake-up in current mode, snapshot on the drop
  task automatic t_wake();
    int n;
    wrt(A_STORED_TRIM, 32'he1);
    wrt(A_STARTUP_TARGET, 32'h2);
    wrt(A_READY_LIMIT, 32'h4);
    wrt(A_TRIM_CTRL, 32'h0201);
    wrt(A_IRQ_STAT, 32'h7);
    kick(1'b1);
    @(negedge clk);
    `CHK("rc rate on wake", 1'b0, drc)
    wait_irq(n);
    `CHK("lp clocked count", 1'b1, n >= 20 && n <= 40)
    `CHK("no apply before drop", exp_cap(8'h3c), cap)
    @(posedge clk);
    drop <= 1'b1;
    @(posedge clk);
    drop <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("cap after drop", exp_cap(8'he1), cap)
    rdc(A_SNAPSHOT, 32'h4);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    @(negedge clk);
    `CHK("xtal off after stop", 1'b0, xtal_en)
    wrt(A_IRQ_STAT, 32'h7);
  endtask
  // every source measured in turn, repeated runs as recalibration
  task automatic t_cal();
    logic [31:0] q, hi, lo;
    int t, p;
    for (int s = 0; s < NUM_SRC; s++) begin
      p = 3 + 3 * s * s;
      wrt(A_REF_COUNT, 32'h5);
      wrt(A_CAL_CTRL, 32'h4 | 32'(s));
      wrt(A_REF_COUNT, 32'h9);
      t = 0;
      q = 32'h4;
      while (q[CAL_GO_BIT] !== 1'b0 && t < 100) begin
        rdv(A_CAL_CTRL, q);
        t++;
      end
      `CHK("go cleared", 1'b0, q[CAL_GO_BIT])
      rdv(A_RESULT_HIGH, hi);
      rdv(A_RESULT_LOW, lo);
      q = {hi[15:0], lo[15:0]};
      `CHK("ref span", 1'b1, q >= 4 * p - 1 && q <= 5 * p + 2)
      rdc(A_REF_COUNT, 32'h5);
      rdc(A_IRQ_STAT, 32'h4);
      wrt(A_IRQ_STAT, 32'h4);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_trim();
    t_pwr();
    t_wake();
    t_cal();
    complete_run();
  end
endmodule // test_xtal_trim_and_osc_calibration
